// *** rtl/ct_irq_consts.vh ***
// Address map, field positions, reset values and modes of the counter/timer and interrupt block
`ifndef CT_IRQ_CONSTS_VH
`define CT_IRQ_CONSTS_VH

// ==========================================================
// Register addresses, four-bit host address
`define ADDR_INTERRUPT_STATUS    4'h5
`define ADDR_INTERRUPT_MASK      4'h5
`define ADDR_AUX_CONTROL         4'h4
`define ADDR_TIMER_COUNT_UPPER   4'h6
`define ADDR_TIMER_COUNT_LOWER   4'h7
`define ADDR_TIMER_PRELOAD_UPPER 4'h6
`define ADDR_TIMER_PRELOAD_LOWER 4'h7
`define ADDR_START_COUNTER       4'hE
`define ADDR_STOP_COUNTER        4'hF

// ==========================================================
// Interrupt status bit positions
`define STAT_TX_A   0
`define STAT_RX_A   1
`define STAT_BRK_A  2
`define STAT_CTR    3
`define STAT_TX_B   4
`define STAT_RX_B   5
`define STAT_BRK_B  6
`define STAT_IN_CHG 7

// ==========================================================
// Aux control mode field
`define AUX_MODE_MSB     6
`define AUX_MODE_LSB     4
`define AUX_MODE_TIMER   2
`define SRC_C_EXT        3'h0
`define SRC_C_TXCA       3'h1
`define SRC_C_TXCB       3'h2
`define SRC_C_XTAL16     3'h3
`define SRC_T_EXT        3'h4
`define SRC_T_EXT16      3'h5
`define SRC_T_XTAL       3'h6
`define SRC_T_XTAL16     3'h7

// ==========================================================
// Reset values and counts
`define RST_STATUS       8'h00
`define RST_MASK         8'h00
`define RST_AUX_MODE     3'h0
`define RST_PRELOAD      16'h0002
`define RST_COUNT        16'h0000
`define RST_RDATA        8'h00
`define PRESCALE_LAST    4'hF
`define COUNT_ZERO       16'h0000
`define COUNT_ONE        16'h0001

`endif

// *** rtl/counter_timer_interrupt_status.v ***
// Counter/timer with interrupt status, mask and active-low interrupt output of a dual UART
`timescale 1ns/100ps
`include "ct_irq_consts.vh"

module counter_timer_interrupt_status (
	// Clock and reset
	input  wire       clock_i,
	input  wire       rst_b_i,
	// Host register bus, same clock
	input  wire [3:0] bus_addr_i,
	input  wire       bus_rd_i,
	input  wire       bus_wr_i,
	input  wire [7:0] bus_wdata_i,
	output wire [7:0] bus_rdata_o,
	// Channel receive events, index 0 is channel A
	input  wire [1:0] chan_mode_one_rx_full_i,
	input  wire [1:0] rx_push_i,
	input  wire [1:0] rx_fifo_full_i,
	input  wire [1:0] rx_holding_read_i,
	input  wire [1:0] rx_fifo_nonempty_i,
	// Channel transmit and break
	input  wire [1:0] chan_transmit_ready_i,
	input  wire [1:0] brk_change_i,
	input  wire [1:0] brk_change_reset_i,
	// Other status and commands
	input  wire       input_change_i,
	input  wire       timeout_disable_i,
	// Counter clock sources
	input  wire       ext_clk_pin_i,
	input  wire       txca_clk_i,
	input  wire       txcb_clk_i,
	// Output port select for the timer pin
	input  wire       timer_pin_select_i,
	// Outputs
	output wire       interrupt_out_n_o,
	output wire       timer_output_pin_o
);

	// ==========================================================
	// Helpers
	function is_timer;
		input [2:0] mode;
		begin
			is_timer = mode[`AUX_MODE_TIMER];
		end
	endfunction

	// ==========================================================
	// Host strobe edges
	reg        rd_prev_q;
	reg        wr_prev_q;
	wire       rd_go;
	wire       wr_go;
	assign rd_go = bus_rd_i & ~rd_prev_q;
	assign wr_go = bus_wr_i & ~wr_prev_q;

	wire start_cmd = rd_go & (bus_addr_i == `ADDR_START_COUNTER);
	wire stop_cmd  = rd_go & (bus_addr_i == `ADDR_STOP_COUNTER);

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= bus_rd_i;
			wr_prev_q <= bus_wr_i;
		end
	end

	// ==========================================================
	// Writable registers
	reg [7:0]  interrupt_mask_q;
	reg [2:0]  aux_mode_q;
	reg [15:0] preload_q;

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			interrupt_mask_q <= `RST_MASK;
			aux_mode_q       <= `RST_AUX_MODE;
			preload_q        <= `RST_PRELOAD;
		end else if (wr_go) begin
			case (bus_addr_i)
				`ADDR_INTERRUPT_MASK: begin
					interrupt_mask_q <= bus_wdata_i;
				end
				`ADDR_AUX_CONTROL: begin
					aux_mode_q <= bus_wdata_i[`AUX_MODE_MSB:`AUX_MODE_LSB];
				end
				`ADDR_TIMER_PRELOAD_UPPER: begin
					preload_q[15:8] <= bus_wdata_i;
				end
				`ADDR_TIMER_PRELOAD_LOWER: begin
					preload_q[7:0] <= bus_wdata_i;
				end
				default: begin
					preload_q <= preload_q;
				end
			endcase
		end
	end

	// ==========================================================
	// Counter clock selection
	// External pin is asynchronous, so two stages before the edge detector
	reg        ext_s1_q;
	reg        ext_s2_q;
	reg        ext_s3_q;
	reg        txca_prev_q;
	reg        txcb_prev_q;
	reg [3:0]  xtal_div_q;
	reg [3:0]  ext_div_q;
	wire       ext_edge  = ext_s2_q & ~ext_s3_q;
	wire       txca_edge = txca_clk_i & ~txca_prev_q;
	wire       txcb_edge = txcb_clk_i & ~txcb_prev_q;
	wire       xtal16    = (xtal_div_q == `PRESCALE_LAST);
	wire       ext16     = ext_edge & (ext_div_q == `PRESCALE_LAST);
	reg        tick;

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_s1_q    <= 1'b0;
			ext_s2_q    <= 1'b0;
			ext_s3_q    <= 1'b0;
			txca_prev_q <= 1'b0;
			txcb_prev_q <= 1'b0;
			xtal_div_q  <= 4'h0;
			ext_div_q   <= 4'h0;
		end else begin
			ext_s1_q    <= ext_clk_pin_i;
			ext_s2_q    <= ext_s1_q;
			ext_s3_q    <= ext_s2_q;
			txca_prev_q <= txca_clk_i;
			txcb_prev_q <= txcb_clk_i;
			xtal_div_q  <= xtal_div_q + 4'h1;
			if (ext_edge) begin
				ext_div_q <= ext_div_q + 4'h1;
			end
		end
	end

	always @* begin
		case (aux_mode_q)
			`SRC_C_EXT:    tick = ext_edge;
			`SRC_C_TXCA:   tick = txca_edge;
			`SRC_C_TXCB:   tick = txcb_edge;
			`SRC_C_XTAL16: tick = xtal16;
			`SRC_T_EXT:    tick = ext_edge;
			`SRC_T_EXT16:  tick = ext16;
			`SRC_T_XTAL:   tick = 1'b1;
			`SRC_T_XTAL16: tick = xtal16;
			default:       tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter/timer core
	reg  [15:0] count_q;
	reg         running_q;
	reg         wave_q;
	reg         ctr_ready_q;
	reg         timer_pin_q;
	wire [15:0] count_dec = count_q - 16'h0001;
	wire        timer_md  = is_timer(aux_mode_q);

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_q     <= `RST_COUNT;
			running_q   <= 1'b0;
			wave_q      <= 1'b1;
		end else if (start_cmd) begin
			count_q   <= preload_q;
			running_q <= 1'b1;
			wave_q    <= 1'b1;
		end else begin
			if (stop_cmd && !timer_md) begin
				running_q <= 1'b0;
				wave_q    <= 1'b1;
			end else if (running_q && tick) begin
				if (timer_md) begin
					// decrement, reload and toggle at zero
					// new preload only at next reload
					if (count_dec == `COUNT_ZERO) begin
						count_q <= preload_q;
						wave_q  <= ~wave_q;
					end else begin
						count_q <= count_dec;
					end
				end else begin
					count_q <= count_dec;
					if (count_dec == `COUNT_ZERO) begin
						wave_q <= 1'b0;
					end
				end
			end
		end
	end

	// Set wins over time-out clear in the same cycle, and over stop in timer mode only
	wire reach_zero = running_q & tick & ~start_cmd & (count_q == `COUNT_ONE);
	// timer mode sets on every second zero, the rising toggle; counter mode on each zero without stop
	wire ctr_set    = reach_zero & (timer_md ? ~wave_q : ~(stop_cmd));

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctr_ready_q <= 1'b0;
		end else if (ctr_set) begin
			ctr_ready_q <= 1'b1;
		end else if (stop_cmd || timeout_disable_i) begin
			ctr_ready_q <= 1'b0;
		end
	end

	// ==========================================================
	// Receive and break status per channel
	wire [1:0] rx_stat;
	wire [1:0] brk_stat;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			reg rx_q;
			reg refill_q;
			reg brk_q;
			// push sets, read clears, refill if more remain
			// full mode sets only on a filling push
			// held character entering counts as filling push
			wire rx_set = chan_mode_one_rx_full_i[ch] ?
			              (rx_push_i[ch] & rx_fifo_full_i[ch]) :
			              (rx_push_i[ch] | (refill_q & rx_fifo_nonempty_i[ch]));
			always @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					rx_q     <= 1'b0;
					refill_q <= 1'b0;
					brk_q    <= 1'b0;
				end else begin
					refill_q <= rx_holding_read_i[ch];
					if (rx_set) begin
						rx_q <= 1'b1;
					end else if (rx_holding_read_i[ch]) begin
						rx_q <= 1'b0;
					end
					if (brk_change_i[ch]) begin
						brk_q <= 1'b1;
					end else if (brk_change_reset_i[ch]) begin
						brk_q <= 1'b0;
					end
				end
			end
			assign rx_stat[ch]  = rx_q;
			assign brk_stat[ch] = brk_q;
		end
	endgenerate

	// ==========================================================
	// Status vector
	wire [7:0] interrupt_status;
	assign interrupt_status[`STAT_TX_A]   = chan_transmit_ready_i[0];
	assign interrupt_status[`STAT_RX_A]   = rx_stat[0];
	assign interrupt_status[`STAT_BRK_A]  = brk_stat[0];
	assign interrupt_status[`STAT_CTR]    = ctr_ready_q;
	assign interrupt_status[`STAT_TX_B]   = chan_transmit_ready_i[1];
	assign interrupt_status[`STAT_RX_B]   = rx_stat[1];
	assign interrupt_status[`STAT_BRK_B]  = brk_stat[1];
	assign interrupt_status[`STAT_IN_CHG] = input_change_i;

	// ==========================================================
	// Read data and outputs
	reg [7:0] rdata_q;
	reg       irq_n_q;

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q     <= `RST_RDATA;
			irq_n_q     <= 1'b1;
			timer_pin_q <= 1'b1;
		end else begin
			// low when any unmasked status bit set
			irq_n_q <= ~|(interrupt_status & interrupt_mask_q);
			timer_pin_q <= timer_pin_select_i ? wave_q : 1'b1;
			if (rd_go) begin
				case (bus_addr_i)
					`ADDR_INTERRUPT_STATUS:  rdata_q <= interrupt_status;
					`ADDR_TIMER_COUNT_UPPER: rdata_q <= count_q[15:8];
					`ADDR_TIMER_COUNT_LOWER: rdata_q <= count_q[7:0];
					default:                 rdata_q <= `RST_RDATA;
				endcase
			end
		end
	end

	assign bus_rdata_o        = rdata_q;
	assign interrupt_out_n_o  = irq_n_q;
	assign timer_output_pin_o = timer_pin_q;

endmodule

// *** sim/ct_irq_chk_sva.sv ***
// Port checker of the counter/timer interrupt block
`timescale 1ns/100ps
module ct_irq_chk (
	// Clock and reset
	input wire       clock_i,
	input wire       rst_b_i,
	// Host bus
	input wire [3:0] bus_addr_i,
	input wire       bus_rd_i,
	input wire       bus_wr_i,
	input wire [7:0] bus_wdata_i,
	input wire [7:0] bus_rdata_o,
	// Status sources and pins
	input wire [1:0] chan_transmit_ready_i,
	input wire       timeout_disable_i,
	input wire       timer_pin_select_i,
	input wire       interrupt_out_n_o,
	input wire       timer_output_pin_o
);
	// ==========================================
	// Shadow of host writes
	reg        rd_q, wr_q, pin_q, st_q, cm_q;
	reg [1:0]  calm_q, live_q;
	reg [7:0]  mask_q;
	reg [2:0]  mode_q;
	reg [15:0] pre_q, run_q;
	wire       rd_r = bus_rd_i && !rd_q;
	wire       wr_r = bus_wr_i && !wr_q;
	wire       start = rd_r && bus_addr_i == 4'hE;
	wire       tog = timer_output_pin_o != pin_q;
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{rd_q, wr_q, st_q, cm_q} <= 4'h0;
			pin_q <= 1'b1;
			calm_q <= 2'h0;
			live_q <= 2'h0;
			mask_q <= 8'h00;
			mode_q <= 3'h0;
			pre_q <= 16'h0002;
			run_q <= 16'h0000;
		end else begin
			rd_q <= bus_rd_i;
			wr_q <= bus_wr_i;
			pin_q <= timer_output_pin_o;
			live_q <= {live_q[0], 1'b1};
			run_q <= tog ? 16'h0001 : run_q + 16'h0001;
			if (start) st_q <= 1'b1;
			if (start) cm_q <= !mode_q[2];
			if (wr_r) cm_q <= 1'b0;
			if (wr_r && bus_addr_i == 4'h4) mode_q <= bus_wdata_i[6:4];
			if (wr_r && bus_addr_i == 4'h5) mask_q <= bus_wdata_i;
			if (wr_r && bus_addr_i == 4'h6) pre_q[15:8] <= bus_wdata_i;
			if (wr_r && bus_addr_i == 4'h7) pre_q[7:0] <= bus_wdata_i;
			// First toggle after a disturbance may end a partial half
			if (wr_r || start || !timer_pin_select_i) calm_q <= 2'h0;
			else if (tog && calm_q != 2'h2) calm_q <= calm_q + 2'h1;
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_start; start; endsequence
	sequence s_stop; rd_r && bus_addr_i == 4'hF; endsequence
	property p_irq_off; (live_q[1] && mask_q == 8'h00) [*2] |-> interrupt_out_n_o; endproperty
	property p_tx_irq; (live_q[1] && mask_q[0] && chan_transmit_ready_i[0]) [*3] |-> !interrupt_out_n_o; endproperty
	property p_rd_status;
		live_q[1] && rd_r && bus_addr_i == 4'h5 && $stable(chan_transmit_ready_i)
		|=> {bus_rdata_o[4], bus_rdata_o[0]} == $past(chan_transmit_ready_i);
	endproperty
	property p_idle_pin; !st_q |-> timer_output_pin_o; endproperty
	// Pin register lags the wave by one edge, so the pin follows two edges after a command
	property p_start_pin; s_start |-> ##2 timer_output_pin_o; endproperty
	property p_stop_pin; s_stop ##0 !mode_q[2] |-> ##2 timer_output_pin_o; endproperty
	property p_cnt_hold;
		cm_q && timer_pin_select_i && !timer_output_pin_o && !rd_r && !$past(rd_r) && !wr_r && !timeout_disable_i
		|=> !timer_output_pin_o;
	endproperty
	property p_half; calm_q == 2'h2 && mode_q == 3'h6 && tog |-> run_q == pre_q; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt low with mask clear");
	a_tx_irq: assert property (p_tx_irq) else $error("masked transmit ready gave no interrupt");
	a_rd_status: assert property (p_rd_status) else $error("status read differs from ready inputs");
	a_idle_pin: assert property (p_idle_pin) else $error("timer pin moved before start");
	a_start_pin: assert property (p_start_pin) else $error("timer pin low after start");
	a_stop_pin: assert property (p_stop_pin) else $error("counter pin low after stop");
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter pin rose without stop");
	a_half: assert property (p_half) else $error("half period differs from preload");
endmodule
bind counter_timer_interrupt_status ct_irq_chk u_chk (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
	.bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
	.chan_transmit_ready_i(chan_transmit_ready_i), .timeout_disable_i(timeout_disable_i),
	.timer_pin_select_i(timer_pin_select_i), .interrupt_out_n_o(interrupt_out_n_o),
	.timer_output_pin_o(timer_output_pin_o)
);

// *** sim/host_bus_model.sv ***
// Host processor model on the register bus
`timescale 1ns/100ps
module host_bus_model (
	// Clock
	input  wire       clock_i,
	// Register bus
	output reg  [3:0] bus_addr_o,
	output reg        bus_rd_o,
	output reg        bus_wr_o,
	output reg  [7:0] bus_wdata_o,
	input  wire [7:0] bus_rdata_i
);
	initial begin
		{bus_rd_o, bus_wr_o} = 2'h0;
		bus_addr_o = 4'h0;
		bus_wdata_o = 8'h00;
	end
	task xfer(input w, input [3:0] a, input [7:0] d, output [7:0] q);
		begin
			@(negedge clock_i);
			bus_addr_o = a;
			bus_wdata_o = d;
			bus_rd_o = !w;
			bus_wr_o = w;
			@(negedge clock_i);
			bus_rd_o = 1'b0;
			bus_wr_o = 1'b0;
			// Released lines show the inverse, not a stale copy
			bus_addr_o = ~a;
			bus_wdata_o = ~d;
			@(negedge clock_i);
			q = bus_rdata_i;
		end
	endtask
endmodule

// *** sim/counter_timer_interrupt_status_tb.sv ***
// Self-checking bench of the counter/timer interrupt block
`timescale 1ns/100ps
module counter_timer_interrupt_status_tb;
	reg        clock_i, rst_b_i, chg, tmo, txca, txcb, ext, sel;
	reg  [1:0] fm, push, full, hrd, ne, txr, brk, bcl;
	reg  [2:0] srcm;
	reg  [7:0] q, n;
	wire [3:0] a;
	wire [7:0] wd, rdat;
	wire       rd, wr, irq_n, pin;
	integer    miscompares, num_checks;
	counter_timer_interrupt_status dut (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_addr_i(a), .bus_rd_i(rd), .bus_wr_i(wr),
		.bus_wdata_i(wd), .bus_rdata_o(rdat), .chan_mode_one_rx_full_i(fm), .rx_push_i(push),
		.rx_fifo_full_i(full), .rx_holding_read_i(hrd), .rx_fifo_nonempty_i(ne),
		.chan_transmit_ready_i(txr), .brk_change_i(brk), .brk_change_reset_i(bcl),
		.input_change_i(chg), .timeout_disable_i(tmo), .ext_clk_pin_i(ext), .txca_clk_i(txca),
		.txcb_clk_i(txcb), .timer_pin_select_i(sel), .interrupt_out_n_o(irq_n), .timer_output_pin_o(pin)
	);
	host_bus_model host (
		.clock_i(clock_i), .bus_addr_o(a), .bus_rd_o(rd), .bus_wr_o(wr), .bus_wdata_o(wd), .bus_rdata_i(rdat)
	);
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// ==========================================
	// Tasks
	task cyc(input integer k); repeat (k) @(negedge clock_i); endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task rd8(input [3:0] ad, input [7:0] e); begin host.xfer(1'b0, ad, 8'h00, q); chk(q, e); end endtask
	task wr8(input [3:0] ad, input [7:0] d); host.xfer(1'b1, ad, d, q); endtask
	task cmd(input [3:0] ad); host.xfer(1'b0, ad, 8'h00, q); endtask
	task ev(input [1:0] p, input [1:0] h, input [1:0] b, input [1:0] c);
		begin
			{push, hrd, brk, bcl} = {p, h, b, c};
			cyc(1);
			{push, hrd, brk, bcl} = 8'h00;
			cyc(1);
		end
	endtask
	// Count latency covers the edge detect on the source clock
	task tick(input integer k);
		begin
			repeat (k) begin
				{ext, txcb, txca} = srcm;
				cyc(1);
				{ext, txcb, txca} = 3'h0;
				cyc(1);
			end
			cyc(2);
		end
	endtask
	task half(output [7:0] len);
		reg v;
		begin
			v = pin;
			len = 8'h00;
			while (pin === v && len < 8'h63) begin cyc(1); len = len + 8'h01; end
			v = pin;
			len = 8'h00;
			while (pin === v && len < 8'h63) begin cyc(1); len = len + 8'h01; end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d miscompares %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		miscompares = miscompares + 1;
		test_done;
	end
	// ==========================================
	// Sequence
	initial begin
		{chg, tmo, txca, sel, rst_b_i} = 5'h02;
		{push, full, hrd, ne, txr, brk, bcl} = 14'h0000;
		fm = 2'b10;
		{ext, txcb, srcm} = 5'h01;
		{miscompares, num_checks} = 64'h0;
		cyc(2);
		rst_b_i = 1'b1;
		rd8(4'h5, 8'h00);
		rd8(4'h6, 8'h00);
		txr = 2'b01;
		chg = 1'b1;
		rd8(4'h5, 8'h81);
		chk(irq_n, 1'b1);
		wr8(4'h5, 8'h01);
		cyc(2);
		chk(irq_n, 1'b0);
		wr8(4'h5, 8'h10);
		cyc(2);
		chk(irq_n, 1'b1);
		rd8(4'h5, 8'h81);
		txr = 2'b10;
		cyc(2);
		chk(irq_n, 1'b0);
		rd8(4'h5, 8'h90);
		{txr, chg} = 3'h0;
		ev(2'b00, 2'b00, 2'b01, 2'b00);
		ev(2'b00, 2'b00, 2'b10, 2'b01);
		rd8(4'h5, 8'h40);
		ev(2'b00, 2'b00, 2'b00, 2'b10);
		rd8(4'h5, 8'h00);
		ne = 2'b01;
		ev(2'b11, 2'b00, 2'b00, 2'b00);
		rd8(4'h5, 8'h02);
		ev(2'b00, 2'b01, 2'b00, 2'b00);
		rd8(4'h5, 8'h02);
		ne = 2'b00;
		full = 2'b10;
		ev(2'b10, 2'b01, 2'b00, 2'b00);
		rd8(4'h5, 8'h20);
		ev(2'b00, 2'b10, 2'b00, 2'b00);
		rd8(4'h5, 8'h00);
		ev(2'b10, 2'b00, 2'b00, 2'b00);
		rd8(4'h5, 8'h20);
		ev(2'b00, 2'b10, 2'b00, 2'b00);
		full = 2'b00;
		wr8(4'h7, 8'h05);
		wr8(4'h4, 8'h60);
		cmd(4'hE);
		half(n);
		chk(n, 16'h0005);
		half(n);
		chk(n, 16'h0005);
		rd8(4'h5, 8'h08);
		cmd(4'hF);
		wr8(4'h7, 8'h03);
		half(n);
		chk(n, 16'h0003);
		half(n);
		chk(n, 16'h0003);
		wr8(4'h4, 8'h10);
		cmd(4'hF);
		wr8(4'h7, 8'h04);
		cmd(4'hE);
		tick(3);
		rd8(4'h7, 8'h01);
		chk(pin, 1'b1);
		tick(1);
		chk(pin, 1'b0);
		rd8(4'h5, 8'h08);
		tick(2);
		rd8(4'h6, 8'hFF);
		rd8(4'h7, 8'hFE);
		tmo = 1'b1;
		cyc(1);
		tmo = 1'b0;
		rd8(4'h5, 8'h00);
		cmd(4'hF);
		chk(pin, 1'b1);
		wr8(4'h7, 8'h07);
		rd8(4'h7, 8'hFE);
		cmd(4'hE);
		rd8(4'h7, 8'h07);
		cmd(4'hF);
		cmd(4'hE);
		rd8(4'h7, 8'h07);
		srcm = 3'h4;
		wr8(4'h4, 8'h00);
		cmd(4'hE);
		tick(2);
		rd8(4'h7, 8'h05);
		srcm = 3'h2;
		wr8(4'h4, 8'h20);
		cmd(4'hE);
		tick(1);
		rd8(4'h7, 8'h06);
		wr8(4'h4, 8'h30);
		cmd(4'hE);
		cyc(30);
		rd8(4'h7, 8'h05);
		srcm = 3'h4;
		wr8(4'h7, 8'h02);
		wr8(4'h4, 8'h40);
		cmd(4'hE);
		tick(1);
		rd8(4'h7, 8'h01);
		wr8(4'h4, 8'h50);
		cmd(4'hE);
		tick(16);
		rd8(4'h7, 8'h01);
		wr8(4'h4, 8'h70);
		cmd(4'hE);
		half(n);
		half(n);
		chk(n, 16'h0020);
		test_done;
	end
endmodule
